// [src/adc_control_result_regs.sv]
// Converter control, channel and reference hold, and result registers.
// Assumes an Avalon-MM master on mclk and a converter core on the same clock.
// Notes on behaviour
// [RL1] Result updates only on conversion completion.
// [RL2] Single-ended code unsigned, saturates at 0x3FF.
// [RL3] Differential code two's complement, clamped to range.
// [RL4] Reference field selects external, supply, internal.
// [RL5] Reference change waits for running conversion end.
// [RL6] Alignment bit changes presentation immediately.
// [RL7] Channel field decodes pins, pairs, bandgap, ground.
// [RL8] Channel change waits for running conversion end.
// [RL9] Enable powers converter; clearing aborts conversion.
// [RL10] Software starts each single conversion.
// [RL11] First conversion 25 cycles, later ones 13.
// [RL12] Start bit reads busy; writing zero ignored.
// [RL13] Done flag set on completion, cleared by one.
// [RL14] Result byte layout follows alignment bit.
// [RL15] Low byte read locks result until high read.
// [RL16] Divider code selects system clock divide ratio.
`timescale 1ns/1ps
module adc_control_result_regs import adc_pkg::*; (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic [CODE_W-1:0] core_code,
    input  wire logic              vector_taken,
    output logic                   core_power,
    output logic                   core_sample,
    output logic                   core_init,
    output logic      [2:0]        chan_pos,
    output logic      [1:0]        chan_neg,
    output logic      [1:0]        chan_kind,
    output logic      [REF_W-1:0]  ref_sel,
    output logic                   internal_ref_on,
    output logic                   conv_done_irq,
    output logic                   irq
);
    conv_state_t       state_r;
    logic              wait_r;
    logic [31:0]       rdata_r;
    logic              en_r;
    logic              ate_r;
    logic              ie_r;
    logic [DIV_W-1:0]  div_r;
    logic              flag_r;
    logic [7:0]        sel_r;
    logic [4:0]        tcnt_r;
    logic              first_r;
    logic              conv_first_r;
    logic [RES_W-1:0]  result_r;
    logic              lock_r;
    logic [2:0]        pos_r;
    logic [1:0]        neg_r;
    logic [1:0]        kind_r;
    logic [REF_W-1:0]  ref_r;
    logic              int_ref_r;
    logic              sample_r;
    logic              done_irq_r;
    logic              irq_r;
    logic [EV_W-1:0]   ev_stat_r;
    logic [EV_W-1:0]   ev_en_r;
    logic [4:0]        hlp_ticks_r;
    wire               tick;
    wire  [7:0]        res_lo;
    wire  [7:0]        res_hi;

    // Bus decode; a request completes at the edge where waitrequest is low.
    wire [IDX_W-1:0]  idx      = avs_address[ADDR_W-1:2];
    wire              req      = avs_read | avs_write;
    wire              rd_acc   = avs_read & ~wait_r;
    wire              wr_acc   = avs_write & ~wait_r & avs_byteenable[0];
    wire [7:0]        wd       = avs_writedata[7:0];
    wire              hit_lo   = idx == IDX_RES_LO;
    wire              hit_hi   = idx == IDX_RES_HI;
    wire              hit_ctrl = idx == IDX_CTRL;
    wire              hit_sel  = idx == IDX_SEL;
    wire              hit_evs  = idx == IDX_EV_STAT;
    wire              hit_evc  = idx == IDX_EV_CLR;
    wire              hit_eve  = idx == IDX_EV_EN;
    wire              wr_ctrl  = wr_acc & hit_ctrl;
    wire              lo_cap   = avs_read & wait_r & hit_lo;
    wire              busy     = state_r == ST_CONV;

    // Conversion control decode.
    wire              start_req = wr_ctrl & wd[CTRL_START_BIT] & wd[CTRL_EN_BIT]; // RL12
    wire              abort     = wr_ctrl & ~wd[CTRL_EN_BIT];
    wire              start_go  = state_r == ST_IDLE & start_req;
    wire [4:0]        conv_len  = conv_first_r ? LEN_FIRST : LEN_NORMAL; // RL11
    wire              done_p    = busy & tick & tcnt_r == conv_len & ~abort;
    wire              restart   = done_p & ate_r;
    wire              flag_clr  = (wr_ctrl & wd[CTRL_FLAG_BIT]) | vector_taken; // RL13
    wire [EV_W-1:0]   ev_set    = {done_p & (lock_r | lo_cap), done_p};
    wire [EV_W-1:0]   ev_clr    = (wr_acc & hit_evc) ? wd[EV_W-1:0] : '0;
    wire [7:0]        ctrl_rd   = {en_r, busy, ate_r, flag_r, ie_r, div_r}; // RL12

    // Channel decode of the pending selection.
    wire [4:0]        ch      = sel_r[CHAN_W-1:0];
    wire              pair_n1 = ch[4:3] == 2'b10;
    wire              pair_n2 = ch[4:3] == 2'b11 && ch[2:0] < CH_N2_LIMIT;
    wire [1:0]        dec_neg = pair_n1 ? NEG_IN1 : (pair_n2 ? NEG_IN2 : NEG_NONE); // RL7
    wire [1:0]        dec_kind = (ch == CH_BANDGAP) ? KIND_BANDGAP : // RL7
                                 (ch == CH_GROUND) ? KIND_GROUND :
                                 (ch[4:3] == 2'b01 || (ch[4:3] == 2'b11 && !pair_n2)) ? KIND_UNUSED :
                                 KIND_PIN;
    wire              hold_ok = ~busy | done_p;

    // Result coding for the applied input mode.
    wire signed [10:0] code_s   = $signed(core_code);
    wire [9:0]        se_code   = core_code[10] ? SE_MAX : core_code[9:0]; // RL2
    wire [9:0]        diff_code = (code_s > DIFF_HI_S) ? DIFF_MAX : // RL3
                                  (code_s < DIFF_LO_S) ? DIFF_MIN : core_code[9:0];
    wire [9:0]        new_res   = (neg_r != NEG_NONE) ? diff_code : se_code;

    wire [7:0]        rd_mux = hit_lo ? res_lo :
                               hit_hi ? res_hi :
                               hit_ctrl ? ctrl_rd :
                               hit_sel ? sel_r :
                               hit_evs ? {6'h00, ev_stat_r} :
                               hit_eve ? {6'h00, ev_en_r} : 8'h00;

    conv_clock_divider #(.CODE_W(DIV_W)) u_div (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .run      (busy & ~restart),
        .div_code (div_r),
        .tick     (tick)
    );

    result_presenter u_pres (
        .result     (result_r),
        .left_align (sel_r[SEL_ALIGN_BIT]),
        .res_lo     (res_lo),
        .res_hi     (res_hi)
    );

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= ~(req & wait_r);
            if (req & wait_r) begin
                rdata_r <= {24'h00_0000, rd_mux};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            {en_r, ate_r, ie_r, div_r} <= {CTRL_RESET[7], CTRL_RESET[5], CTRL_RESET[3], CTRL_RESET[2:0]};
            sel_r   <= SEL_RESET;
            ev_en_r <= EV_RESET;
        end else begin
            if (wr_ctrl) begin
                {en_r, ate_r, ie_r, div_r} <= {wd[7], wd[5], wd[3], wd[2:0]}; // RL9
            end
            if (wr_acc & hit_sel) begin
                sel_r <= wd;
            end
            if (wr_acc & hit_eve) begin
                ev_en_r <= wd[EV_W-1:0];
            end
        end
    end

    // Conversion sequencer.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_r      <= ST_IDLE;
            tcnt_r       <= 5'h00;
            conv_first_r <= 1'b0;
            sample_r     <= 1'b0;
        end else begin
            sample_r <= start_go | restart;
            case (state_r)
                ST_IDLE: begin
                    if (start_go) begin // RL10
                        state_r      <= ST_CONV;
                        tcnt_r       <= 5'h00;
                        conv_first_r <= first_r; // RL11
                    end
                end
                ST_CONV: begin
                    if (abort) begin // RL9
                        state_r      <= ST_IDLE;
                        conv_first_r <= 1'b0;
                    end else if (done_p) begin
                        state_r      <= ate_r ? ST_CONV : ST_IDLE;
                        tcnt_r       <= 5'h00;
                        conv_first_r <= 1'b0;
                    end else if (tick) begin
                        tcnt_r <= tcnt_r + 5'h01;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // A conversion started while disabled or together with enable initialises.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            first_r <= 1'b1;
        end else if (start_go) begin
            first_r <= 1'b0;
        end else if (!en_r) begin
            first_r <= 1'b1; // RL11
        end
    end

    // Channel and reference reach the core only between conversions.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pos_r     <= 3'h0;
            neg_r     <= NEG_NONE;
            kind_r    <= KIND_PIN;
            ref_r     <= SEL_RESET[7:6];
            int_ref_r <= 1'b0;
        end else if (hold_ok) begin
            pos_r     <= ch[2:0]; // RL8
            neg_r     <= dec_neg;
            kind_r    <= dec_kind;
            ref_r     <= sel_r[SEL_REF_LSB +: REF_W]; // RL5
            int_ref_r <= sel_r[SEL_REF_LSB +: REF_W] == REF_INTERNAL; // RL4
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            result_r <= 10'h000;
            lock_r   <= 1'b0;
        end else begin
            // The lock starts at the edge that captures the low byte, so the pair never tears.
            if (done_p & ~lock_r & ~lo_cap) begin
                result_r <= new_res; // RL1
            end
            if (lo_cap) begin
                lock_r <= 1'b1; // RL15
            end else if (rd_acc & hit_hi) begin
                lock_r <= 1'b0;
            end
        end
    end

    // Flags: a setting event wins over a clear in the same cycle.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            flag_r     <= 1'b0;
            ev_stat_r  <= EV_RESET;
            done_irq_r <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            flag_r     <= done_p | (flag_r & ~flag_clr); // RL13
            ev_stat_r  <= ev_set | (ev_stat_r & ~ev_clr);
            done_irq_r <= flag_r & ie_r;
            irq_r      <= |(ev_stat_r & ev_en_r);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b || start_go || restart) begin
            hlp_ticks_r <= 5'h00;
        end else if (busy & tick) begin
            hlp_ticks_r <= hlp_ticks_r + 5'h01;
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign core_power      = en_r;
    assign core_sample     = sample_r;
    assign core_init       = conv_first_r;
    assign chan_pos        = pos_r;
    assign chan_neg        = neg_r;
    assign chan_kind       = kind_r;
    assign ref_sel         = ref_r;
    assign internal_ref_on = int_ref_r;
    assign conv_done_irq   = done_irq_r;
    assign irq             = irq_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_done_flag;
        done_p ##1 flag_r;
    endsequence

    AST_RESULT_ONLY_ON_DONE: // RL1
        assert property ($changed(result_r) |-> $past(done_p) && flag_r) else $error("Result moved without completion.");
    AST_SE_SATURATE: // RL2
        assert property (done_p && !lock_r && !lo_cap && neg_r == NEG_NONE && core_code[10] |=> result_r == 10'h3FF)
        else $error("Single-ended overrange not saturated.");
    AST_DIFF_CLAMP: // RL3
        assert property (done_p && !lock_r && !lo_cap && neg_r != NEG_NONE && code_s > 11'sh1FF |=> result_r == 10'h1FF)
        else $error("Differential overrange not clamped.");
    AST_INT_REF: // RL4
        assert property (internal_ref_on == (ref_sel == 2'b11)) else $error("Internal reference mismatch.");
    AST_REF_HELD: // RL5
        assert property (busy && !done_p |=> $stable(ref_sel)) else $error("Reference changed mid conversion.");
    AST_CHAN_HELD: // RL8
        assert property (busy && !done_p |=> $stable(chan_pos) && $stable(chan_neg))
        else $error("Channel changed mid conversion.");
    AST_ABORT: // RL9
        assert property (wr_ctrl && !wd[CTRL_EN_BIT] |=> !busy && !core_power && !$rose(flag_r))
        else $error("Disable did not abort.");
    AST_CONV_LENGTH: // RL11
        assert property (done_p |-> hlp_ticks_r == (conv_first_r ? 5'h18 : 5'h0C)) else $error("Wrong conversion length.");
    AST_START_BUSY: // RL12
        assert property (start_go |=> ctrl_rd[6] && core_sample) else $error("Start bit not busy.");
    AST_FLAG_SET: // RL13
        assert property (done_p |-> s_done_flag) else $error("Completion flag not set.");
    AST_ALIGN_NOW: // RL6
        assert property (sel_r[5] |-> res_hi == result_r[9:2]) else $error("Left alignment wrong.");
    AST_LOCK_HOLD: // RL15
        assert property (lock_r |=> $stable(result_r)) else $error("Result updated while locked.");
endmodule // adc_control_result_regs

// [src/adc_pkg.sv]
// Shared constants of the converter control and result block.
// Assumes a single 40 MHz system clock and an Avalon-MM register slave.
package adc_pkg;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned CHAN_W        = 5;
    localparam int unsigned REF_W         = 2;
    localparam int unsigned DIV_W         = 3;
    localparam int unsigned RES_W         = 10;
    localparam int unsigned CODE_W        = 11;
    localparam int unsigned EV_W          = 2;
    localparam int unsigned ADDR_W        = 10;
    localparam int unsigned IDX_W         = 8;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_RES_LO    = 8'h78;
    localparam logic [7:0] IDX_RES_HI    = 8'h79;
    localparam logic [7:0] IDX_CTRL      = 8'h7A;
    localparam logic [7:0] IDX_SEL       = 8'h7C;
    localparam logic [7:0] IDX_EV_STAT   = 8'h80;
    localparam logic [7:0] IDX_EV_CLR    = 8'h81;
    localparam logic [7:0] IDX_EV_EN     = 8'h82;
    // Field positions of the control and status register.
    localparam int unsigned CTRL_EN_BIT   = 7;
    localparam int unsigned CTRL_START_BIT = 6;
    localparam int unsigned CTRL_ATE_BIT  = 5;
    localparam int unsigned CTRL_FLAG_BIT = 4;
    localparam int unsigned CTRL_IE_BIT   = 3;
    // Field positions of the input and reference select register.
    localparam int unsigned SEL_REF_LSB   = 6;
    localparam int unsigned SEL_ALIGN_BIT = 5;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] SEL_RESET     = 8'h00;
    localparam logic [1:0] EV_RESET      = 2'h0;
    // Event bits.
    localparam int unsigned EV_DONE       = 0;
    localparam int unsigned EV_LOST       = 1;
    // Conversion lengths in converter clock cycles, less one.
    localparam logic [4:0] LEN_FIRST     = 5'h18;
    localparam logic [4:0] LEN_NORMAL    = 5'h0C;
    // Channel decoding.
    localparam logic [4:0] CH_BANDGAP    = 5'h1E;
    localparam logic [4:0] CH_GROUND     = 5'h1F;
    localparam logic [2:0] CH_N2_LIMIT   = 3'h6;
    localparam logic [1:0] KIND_PIN      = 2'h0;
    localparam logic [1:0] KIND_BANDGAP  = 2'h1;
    localparam logic [1:0] KIND_GROUND   = 2'h2;
    localparam logic [1:0] KIND_UNUSED   = 2'h3;
    localparam logic [1:0] NEG_NONE      = 2'h0;
    localparam logic [1:0] NEG_IN1       = 2'h1;
    localparam logic [1:0] NEG_IN2       = 2'h2;
    localparam logic [1:0] REF_INTERNAL  = 2'h3;
    // Result codes.
    localparam logic [9:0] SE_MAX        = 10'h3FF;
    localparam logic [9:0] DIFF_MAX      = 10'h1FF;
    localparam logic [9:0] DIFF_MIN      = 10'h200;
    localparam logic signed [10:0] DIFF_HI_S = 11'sh1FF;
    localparam logic signed [10:0] DIFF_LO_S = 11'sh600;
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_CONV = 2'b10} conv_state_t;
endpackage

// [src/conv_clock_divider.sv]
// Prescaler that turns the system clock into converter clock ticks.
// Assumes run is a same-clock level; counting restarts while run is low.
`timescale 1ns/1ps
module conv_clock_divider import adc_pkg::*; #(
    parameter int unsigned CODE_W = DIV_W
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              run,
    input  wire logic [CODE_W-1:0] div_code,
    output logic                   tick
);
    localparam int unsigned CNT_W = 1 << CODE_W;
    if (CODE_W < 1 || CODE_W > 4) begin : g_chk
        $error("Divider code width out of range.");
    end
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] limit;
    logic             tick_r;
    // Codes zero and one both divide by two, then each code doubles. // RL16
    assign limit = (div_code <= CODE_W'(1)) ? CNT_W'(1) : CNT_W'((CNT_W'(1) << div_code) - CNT_W'(1));
    always_ff @(posedge mclk) begin
        if (!rst_b || !run || cnt_r == limit) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= run && cnt_r == limit;
        end
    end
    assign tick = tick_r;
endmodule // conv_clock_divider

// [src/result_presenter.sv]
// Places the ten-bit result into the low and high result bytes.
// Assumes the alignment bit may change at any time; output follows at once.
`timescale 1ns/1ps
module result_presenter import adc_pkg::*; (
    input  wire logic [RES_W-1:0]  result,
    input  wire logic              left_align,
    output logic      [DATA_W-1:0] res_lo,
    output logic      [DATA_W-1:0] res_hi
);
    // Left: bits 9:2 high, bits 1:0 on top of low; right: bits 9:8 low of high. // RL14
    assign res_lo = left_align ? {result[1:0], 6'h00} : result[7:0]; // RL6
    assign res_hi = left_align ? result[9:2] : {6'h00, result[9:8]}; // RL6
endmodule // result_presenter

// [dv/core_model.sv]
// Stand-in for the analog multiplexer and converter core.
// Assumes the control block pulses core_sample as each conversion starts.
`timescale 1ns/1ps
module core_model import adc_pkg::*; (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              core_power,
    input  wire logic              core_sample,
    input  wire logic [CODE_W-1:0] level,
    output logic      [CODE_W-1:0] core_code
);
    logic [CODE_W-1:0] held_r;
    // The code is taken at the sample pulse and held for the conversion.
    always_ff @(posedge mclk) begin
        if (!rst_b) held_r <= '0;
        else if (core_sample) held_r <= level;
    end
    // A powered-down core does not keep its last code on the lines.
    assign core_code = core_power ? held_r : ~held_r;
endmodule // core_model

// [dv/adc_control_result_regs_tb_top.sv]
// Self-checking bench of the converter control and result block.
// Assumes the core model above and an Avalon-MM master driven from here.
`timescale 1ns/1ps
module adc_control_result_regs_tb_top import adc_pkg::*;;
    typedef struct packed {
        logic [7:0] sel;
        logic [10:0] code;
        logic [9:0] res;
        logic [2:0] pos;
        logic [1:0] neg;
        logic [1:0] kind;
    } row_t;
    logic              mclk, rst_b, avs_read, avs_write, vector_taken, irq_q;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0]       avs_writedata, avs_readdata;
    logic [3:0]        avs_byteenable;
    logic              avs_waitrequest, core_power, core_sample, core_init;
    logic              internal_ref_on, conv_done_irq, irq;
    logic [CODE_W-1:0] core_code, level;
    logic [2:0]        chan_pos;
    logic [1:0]        chan_neg, chan_kind, ref_sel;
    logic [7:0]        lo, hi, q;
    int                n_fail, n_tests, cyc, run_cnt, last_len;
    int                lens[10];
    logic [7:0]        regs[6] = '{IDX_CTRL, IDX_SEL, IDX_RES_LO, IDX_RES_HI, IDX_EV_STAT, IDX_EV_EN};
    row_t rows[10] = '{
        '{8'h00, 11'h000, 10'h000, 3'h0, 2'h0, 2'h0}, '{8'h67, 11'h3FF, 10'h3FF, 3'h7, 2'h0, 2'h0},
        '{8'h47, 11'h400, 10'h3FF, 3'h7, 2'h0, 2'h0}, '{8'hFB, 11'h7A3, 10'h3A3, 3'h3, 2'h2, 2'h0},
        '{8'hD0, 11'h3FF, 10'h1FF, 3'h0, 2'h1, 2'h0}, '{8'h97, 11'h400, 10'h200, 3'h7, 2'h1, 2'h0},
        '{8'h1D, 11'h600, 10'h200, 3'h5, 2'h2, 2'h0}, '{8'hDE, 11'h155, 10'h155, 3'h0, 2'h0, 2'h1},
        '{8'h3F, 11'h000, 10'h000, 3'h0, 2'h0, 2'h2}, '{8'h08, 11'h000, 10'h000, 3'h0, 2'h0, 2'h3}};

    adc_control_result_regs u_adc_control_result_regs (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .core_code(core_code), .vector_taken(vector_taken), .core_power(core_power),
        .core_sample(core_sample), .core_init(core_init), .chan_pos(chan_pos), .chan_neg(chan_neg),
        .chan_kind(chan_kind), .ref_sel(ref_sel), .internal_ref_on(internal_ref_on),
        .conv_done_irq(conv_done_irq), .irq(irq));
    core_model u_core_model (.mclk(mclk), .rst_b(rst_b), .core_power(core_power), .core_sample(core_sample),
        .level(level), .core_code(core_code));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic summarize;
        if (n_fail == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Conversion length is measured from the sample pulse to the event interrupt.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        irq_q <= irq;
        run_cnt <= core_sample ? 0 : run_cnt + 1;
        if (irq && !irq_q) last_len <= run_cnt;
        if (cyc == 30000) begin
            n_fail = n_fail + 1;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Returns the high byte above the low byte.
    function automatic logic [15:0] lay(input logic [9:0] r, input logic al);
        return al ? {r[9:2], r[1:0], 6'h00} : {6'h00, r[9:8], r[7:0]};
    endfunction

    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] rdq);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= ~w;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        rdq = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] rdq);
        bus(1'b0, idx, 8'h00, rdq);
    endtask

    task automatic conv(input logic [10:0] code, input logic [7:0] ctl);
        logic [7:0] s;
        level <= code;
        wr(IDX_CTRL, ctl);
        s = 8'h00;
        for (int k = 0; k < 1000 && s[CTRL_FLAG_BIT] !== 1'b1; k++) rd(IDX_CTRL, s);
        chk("done flag", 16'h1, {15'h0, s[CTRL_FLAG_BIT]});
    endtask

    task automatic clr;
        wr(IDX_CTRL, 8'h98);
        wr(IDX_EV_CLR, 8'h03);
    endtask

    initial begin
        {rst_b, avs_read, avs_write, vector_taken, irq_q} = '0;
        avs_address = '0;
        avs_writedata = '0;
        avs_byteenable = 4'hF;
        level = '0;
        {n_fail, n_tests, cyc, run_cnt, last_len} = '0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        wr(IDX_EV_EN, 8'h01);
        for (int i = 0; i < 10; i++) begin
            wr(IDX_SEL, rows[i].sel);
            conv(rows[i].code, 8'hC8);
            rd(IDX_RES_LO, lo);
            rd(IDX_RES_HI, hi);
            chk("result", lay(rows[i].res, rows[i].sel[SEL_ALIGN_BIT]), {hi, lo});
            chk("kind", {14'h0, rows[i].kind}, {14'h0, chan_kind});
            if (rows[i].kind === KIND_PIN) chk("pair", {11'h0, rows[i].pos, rows[i].neg}, {11'h0, chan_pos, chan_neg});
            chk("ref", {13'h0, rows[i].sel[7:6] == 2'b11, rows[i].sel[7:6]}, {13'h0, internal_ref_on, ref_sel});
            chk("irq", 16'h3, {14'h0, conv_done_irq, irq});
            lens[i] = last_len;
            clr();
        end
        chk("first length", 16'h0018, 16'(lens[0] - lens[1]));
        for (int d = 1; d < 8; d++) begin
            conv(11'h155, 8'hC8 | 8'(d));
            chk("divided length", 16'(13 * ((d < 2 ? 2 : (1 << d)) - 2)), 16'(last_len - lens[1]));
            clr();
        end
        wr(IDX_SEL, 8'h47);
        conv(11'h2C5, 8'hC8);
        clr();
        level <= 11'h0AA;
        wr(IDX_CTRL, 8'hCB);
        wr(IDX_SEL, 8'hE2);
        @(posedge mclk);
        chk("held select", 16'h000F, {11'h0, ref_sel, chan_pos});
        rd(IDX_RES_LO, lo);
        rd(IDX_RES_HI, hi);
        chk("realign", lay(10'h2C5, 1'b1), {hi, lo});
        wr(IDX_CTRL, 8'h8B);
        rd(IDX_CTRL, q);
        chk("busy", 16'h1, {15'h0, q[CTRL_START_BIT]});
        conv(11'h0AA, 8'h8B);
        rd(IDX_CTRL, q);
        chk("idle", 16'h0, {15'h0, q[CTRL_START_BIT]});
        chk("applied select", 16'h001A, {11'h0, ref_sel, chan_pos});
        rd(IDX_RES_LO, lo);
        rd(IDX_RES_HI, hi);
        chk("new result", lay(10'h0AA, 1'b1), {hi, lo});
        clr();
        rd(IDX_RES_LO, lo);
        conv(11'h111, 8'hC8);
        rd(IDX_RES_HI, hi);
        chk("locked", lay(10'h0AA, 1'b1), {hi, lo});
        rd(IDX_EV_STAT, q);
        chk("events", 16'h3, {8'h0, q});
        clr();
        conv(11'h001, 8'hC8);
        vector_taken <= 1'b1;
        @(posedge mclk);
        vector_taken <= 1'b0;
        rd(IDX_CTRL, q);
        chk("vector clear", 16'h0, {15'h0, q[CTRL_FLAG_BIT]});
        chk("irq lines", 16'h1, {14'h0, conv_done_irq, irq});
        wr(IDX_EV_EN, 8'h00);
        @(posedge mclk);
        chk("masked", 16'h0, {15'h0, irq});
        wr(IDX_EV_EN, 8'h01);
        @(posedge mclk);
        chk("unmasked", 16'h1, {15'h0, irq});
        wr(IDX_EV_CLR, 8'h01);
        @(posedge mclk);
        chk("cleared", 16'h0, {15'h0, irq});
        level <= 11'h0F0;
        wr(IDX_CTRL, 8'hCB);
        repeat (10) @(posedge mclk);
        wr(IDX_CTRL, 8'h03);
        @(posedge mclk);
        chk("power off", 16'h0, {15'h0, core_power});
        repeat (300) @(posedge mclk);
        rd(IDX_CTRL, q);
        chk("aborted", 16'h03, {8'h0, q});
        wr(IDX_CTRL, 8'hE8);
        chk("init", 16'h1, {15'h0, core_init});
        conv(11'h0F0, 8'hB8);
        chk("init done", 16'h0, {15'h0, core_init});
        conv(11'h0F0, 8'hB8);
        rd(IDX_CTRL, q);
        chk("free run", 16'h1, {15'h0, q[CTRL_START_BIT]});
        wr(IDX_CTRL, 8'h00);
        avs_byteenable <= 4'hE;
        wr(IDX_SEL, 8'h00);
        avs_byteenable <= 4'hF;
        rd(IDX_SEL, q);
        chk("byte lane", 16'hE2, {8'h0, q});
        wr(8'h7B, 8'hFF);
        rd(8'h7B, q);
        chk("unmapped", 16'h0, {8'h0, q});
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        for (int r = 0; r < 6; r++) begin
            rd(regs[r], q);
            chk("reset value", 16'h0, {8'h0, q});
        end
        chk("reset lines", 16'h0, {13'h0, core_power, conv_done_irq, irq});
        summarize();
    end
endmodule // adc_control_result_regs_tb_top
